// File: logic/dpc_pkg.sv
package dpc_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA_A = 8'hc0;
  localparam logic [7:0] IDX_DATA_B = 8'hc1;
  localparam logic [7:0] IDX_DIR_A = 8'hc4;
  localparam logic [7:0] IDX_DIR_B = 8'hc5;
  localparam logic [7:0] IDX_OPT_A = 8'hcc;
  localparam logic [7:0] IDX_OPT_B = 8'hcd;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'hd0;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hd1;

  localparam int GEN_BIT = 0;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
  localparam logic GEN_RESET = 1'b0;

  typedef enum logic [2:0] {
    MODE_IN_PULLUP,
    MODE_IN_FLOAT,
    MODE_IN_IRQ,
    MODE_ANALOG,
    MODE_OUT_OD,
    MODE_OUT_PP
  } dpc_mode_type;

  // Software view of one port
  typedef struct packed {
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] opt;
  } dpc_port_type;

  // Pad controls of one port
  typedef struct packed {
    logic [PORT_W-1:0] out_en;
    logic [PORT_W-1:0] out_val;
    logic [PORT_W-1:0] pullup_en;
    logic [PORT_W-1:0] analog_sel;
    logic [PORT_W-1:0] irq_en;
  } dpc_pad_type;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic dpc_mode_type pin_mode(input logic dir, input logic opt, input logic dat);
    if (dir) begin
      pin_mode = opt ? MODE_OUT_PP : MODE_OUT_OD;
    end else if (!opt) begin
      pin_mode = dat ? MODE_IN_FLOAT : MODE_IN_PULLUP;
    end else begin
      pin_mode = dat ? MODE_ANALOG : MODE_IN_IRQ;
    end
  endfunction

endpackage

// File: logic/dpc_gpio.sv
`timescale 1ns/1ps

// Contract
// - Input modes decoded from option and data
// - Direction 1 option 0 gives open drain
// - Direction 1 option 1 gives push pull
// - Data read returns latch or pin
// - Data write retunes input pin characteristics
// - Option write retunes input or output style
// - Direction bit selects input or output
// - Interrupt needs irq mode and global enable
// - Ports run on in wait, wake request
// - Ports run on in stop, wake request
// - Data registers at indices c0, c1
// - Direction registers at indices c4, c5
// - Option registers at indices cc, cd
// - Reset clears all port registers
// - Bit x controls pin x
// - Output data write drives pin latch
module dpc_gpio #(
  parameter int PORT_W = dpc_pkg::PORT_W
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [PORT_W-1:0] pin_in_a, // Port A pad levels
  input wire logic [PORT_W-1:0] pin_in_b, // Port B pad levels
  output dpc_pkg::dpc_pad_type pad_a, // Port A pad controls
  output dpc_pkg::dpc_pad_type pad_b, // Port B pad controls
  output logic [PORT_W-1:0] pin_sync_a, // Port A synchronised levels
  output logic [PORT_W-1:0] pin_sync_b, // Port B synchronised levels
  output logic ext_irq_req, // Pin interrupt request
  output logic wake_req // Wake from wait or stop
);

  if (PORT_W != dpc_pkg::PORT_W) begin : g_bad_width
    $error("dpc_gpio supports only the 8-bit port width");
  end

  dpc_pkg::dpc_port_type port_a_reg;
  dpc_pkg::dpc_port_type port_b_reg;
  logic global_irq_enable_reg;
  logic [PORT_W-1:0] meta_a_reg;
  logic [PORT_W-1:0] meta_b_reg;
  logic [PORT_W-1:0] sync_a_reg;
  logic [PORT_W-1:0] sync_b_reg;
  logic [PORT_W-1:0] irq_hit_a_reg;
  logic [PORT_W-1:0] irq_hit_b_reg;
  dpc_pkg::dpc_pad_type pad_a_next;
  dpc_pkg::dpc_pad_type pad_b_next;
  logic [PORT_W-1:0] irq_hit_a_next;
  logic [PORT_W-1:0] irq_hit_b_next;
  logic access;
  logic wr_fire;
  logic [31:0] rd_next;
  logic err_next;

  function automatic dpc_pkg::dpc_pad_type pad_decode(input dpc_pkg::dpc_port_type p);
    dpc_pkg::dpc_mode_type m;
    pad_decode = '0;
    for (int i = 0; i < dpc_pkg::PORT_W; i++) begin
      m = dpc_pkg::pin_mode(p.dir[i], p.opt[i], p.data[i]);
      case (m)
        dpc_pkg::MODE_IN_PULLUP: begin
          pad_decode.pullup_en[i] = 1'b1;
        end
        dpc_pkg::MODE_IN_FLOAT: begin
          pad_decode.pullup_en[i] = 1'b0;
        end
        dpc_pkg::MODE_IN_IRQ: begin
          pad_decode.pullup_en[i] = 1'b1;
          pad_decode.irq_en[i] = 1'b1;
        end
        dpc_pkg::MODE_ANALOG: begin
          pad_decode.analog_sel[i] = 1'b1;
        end
        dpc_pkg::MODE_OUT_OD: begin
          // P driver off: drive low only when latch is 0
          pad_decode.out_en[i] = ~p.data[i];
          pad_decode.out_val[i] = 1'b0;
        end
        default: begin
          pad_decode.out_en[i] = 1'b1;
          pad_decode.out_val[i] = p.data[i];
        end
      endcase
    end
  endfunction

  // Input pins read the pad, output pins the latch
  function automatic logic [31:0] data_view(input dpc_pkg::dpc_port_type p,
                                            input logic [PORT_W-1:0] pins);
    data_view = {24'h000000, (p.dir & p.data) | (~p.dir & pins)};
  endfunction

  // Two-stage pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_a_reg <= dpc_pkg::PORT_RESET;
      meta_b_reg <= dpc_pkg::PORT_RESET;
      sync_a_reg <= dpc_pkg::PORT_RESET;
      sync_b_reg <= dpc_pkg::PORT_RESET;
    end else begin
      meta_a_reg <= pin_in_a;
      meta_b_reg <= pin_in_b;
      sync_a_reg <= meta_a_reg;
      sync_b_reg <= meta_b_reg;
    end
  end

  assign access = psel && penable;
  assign wr_fire = access && pready && pwrite;

  // Read mux and address decode
  always_comb begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_A)) begin
      rd_next = data_view(port_a_reg, sync_a_reg);
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_B)) begin
      rd_next = data_view(port_b_reg, sync_b_reg);
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DIR_A)) begin
      rd_next = {24'h000000, port_a_reg.dir};
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DIR_B)) begin
      rd_next = {24'h000000, port_b_reg.dir};
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_OPT_A)) begin
      rd_next = {24'h000000, port_a_reg.opt};
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_OPT_B)) begin
      rd_next = {24'h000000, port_b_reg.opt};
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_IRQ_CTRL)) begin
      rd_next = {31'h00000000, global_irq_enable_reg};
    end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_IRQ_STAT)) begin
      rd_next = {16'h0000, irq_hit_b_reg, irq_hit_a_reg};
    end else begin
      err_next = 1'b1;
    end
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_next;
      pslverr <= err_next;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Port A registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_a_reg <= {3{dpc_pkg::PORT_RESET}};
    end else if (wr_fire) begin
      if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_A)) begin
        port_a_reg.data <= pwdata[PORT_W-1:0];
      end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DIR_A)) begin
        port_a_reg.dir <= pwdata[PORT_W-1:0];
      end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_OPT_A)) begin
        port_a_reg.opt <= pwdata[PORT_W-1:0];
      end
    end
  end

  // Port B registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_b_reg <= {3{dpc_pkg::PORT_RESET}};
    end else if (wr_fire) begin
      if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_B)) begin
        port_b_reg.data <= pwdata[PORT_W-1:0];
      end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DIR_B)) begin
        port_b_reg.dir <= pwdata[PORT_W-1:0];
      end else if (paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_OPT_B)) begin
        port_b_reg.opt <= pwdata[PORT_W-1:0];
      end
    end
  end

  // Global interrupt enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      global_irq_enable_reg <= dpc_pkg::GEN_RESET;
    end else if (wr_fire && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_IRQ_CTRL)) begin
      global_irq_enable_reg <= pwdata[dpc_pkg::GEN_BIT];
    end
  end

  assign pad_a_next = pad_decode(port_a_reg);
  assign pad_b_next = pad_decode(port_b_reg);
  // Low level trigger on irq-configured inputs
  assign irq_hit_a_next = pad_a_next.irq_en & ~sync_a_reg;
  assign irq_hit_b_next = pad_b_next.irq_en & ~sync_b_reg;

  // Registered pad controls and interrupt outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pad_a <= '0;
      pad_b <= '0;
      pin_sync_a <= dpc_pkg::PORT_RESET;
      pin_sync_b <= dpc_pkg::PORT_RESET;
      irq_hit_a_reg <= dpc_pkg::PORT_RESET;
      irq_hit_b_reg <= dpc_pkg::PORT_RESET;
      ext_irq_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      pad_a <= pad_a_next;
      pad_b <= pad_b_next;
      pin_sync_a <= sync_a_reg;
      pin_sync_b <= sync_b_reg;
      irq_hit_a_reg <= irq_hit_a_next;
      irq_hit_b_reg <= irq_hit_b_next;
      ext_irq_req <= global_irq_enable_reg &&
                     (|{irq_hit_a_next, irq_hit_b_next});
      // No low-power input: ports behave the same in wait and stop
      wake_req <= global_irq_enable_reg &&
                  (|{irq_hit_a_next, irq_hit_b_next});
    end
  end

  property p_ready_one_wait;
    @(posedge ref_clk) disable iff (!rst_n)
      (psel && penable && !pready) |=> pready;
  endproperty
  a_ready_one_wait: assert property (p_ready_one_wait)
    else $error("pready not raised one cycle into access");

  property p_reset_clear;
    @(posedge ref_clk) !rst_n |=> (port_a_reg == '0 && port_b_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("port registers not cleared by reset");

  property p_data_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_A))
      |=> port_a_reg.data == $past(pwdata[PORT_W-1:0]);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("port A data write lost");

  property p_dir_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DIR_B))
      |=> port_b_reg.dir == $past(pwdata[PORT_W-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("port B direction write lost");

  property p_pp_drive;
    @(posedge ref_clk) disable iff (!rst_n)
      (port_a_reg.dir[0] && port_a_reg.opt[0])
      |=> (pad_a.out_en[0] && pad_a.out_val[0] == $past(port_a_reg.data[0]));
  endproperty
  a_pp_drive: assert property (p_pp_drive)
    else $error("push-pull pin not driving latch");

  property p_od_drive;
    @(posedge ref_clk) disable iff (!rst_n)
      (port_a_reg.dir[1] && !port_a_reg.opt[1])
      |=> (!pad_a.out_val[1] && pad_a.out_en[1] == !$past(port_a_reg.data[1]));
  endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("open-drain pin drive wrong");

  property p_input_pullup;
    @(posedge ref_clk) disable iff (!rst_n)
      (!port_b_reg.dir[2] && !port_b_reg.data[2])
      |=> (pad_b.pullup_en[2] && !pad_b.out_en[2] && !pad_b.analog_sel[2]);
  endproperty
  a_input_pullup: assert property (p_input_pullup)
    else $error("input pull-up mode wrong");

  property p_analog;
    @(posedge ref_clk) disable iff (!rst_n)
      (!port_b_reg.dir[3] && port_b_reg.opt[3] && port_b_reg.data[3])
      |=> (pad_b.analog_sel[3] && !pad_b.pullup_en[3] && !pad_b.irq_en[3]);
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog mode wrong");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      ext_irq_req |-> ($past(global_irq_enable_reg) && (|(pad_a.irq_en | pad_b.irq_en)));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without enable or irq mode");

  property p_read_input;
    @(posedge ref_clk) disable iff (!rst_n)
      (access && !pready && !pwrite && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_A)
       && port_a_reg.dir == '0) |=> prdata[PORT_W-1:0] == $past(sync_a_reg);
  endproperty
  a_read_input: assert property (p_read_input)
    else $error("input read does not show pins");

  property p_read_output;
    @(posedge ref_clk) disable iff (!rst_n)
      (access && !pready && !pwrite && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_DATA_B)
       && port_b_reg.dir == '1) |=> prdata[PORT_W-1:0] == $past(port_b_reg.data);
  endproperty
  a_read_output: assert property (p_read_output)
    else $error("output read does not show latch");

  property p_opt_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_OPT_A))
      |=> port_a_reg.opt == $past(pwdata[PORT_W-1:0]);
  endproperty
  a_opt_write: assert property (p_opt_write)
    else $error("port A option write lost");

  property p_gen_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && paddr == dpc_pkg::byte_addr(dpc_pkg::IDX_IRQ_CTRL))
      |=> global_irq_enable_reg == $past(pwdata[dpc_pkg::GEN_BIT]);
  endproperty
  a_gen_write: assert property (p_gen_write)
    else $error("global interrupt enable write lost");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n) wake_req == ext_irq_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request and interrupt disagree");

  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_fire);
  c_unmapped: cover property (@(posedge ref_clk) disable iff (!rst_n) pready && pslverr);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) ext_irq_req);
  c_pp: cover property (@(posedge ref_clk) disable iff (!rst_n) pad_b.out_en != '0);
  c_analog: cover property (@(posedge ref_clk) disable iff (!rst_n) pad_b.analog_sel != '0);

endmodule // dpc_gpio

// File: test/dpc_pad_model.sv
`timescale 1ns/1ps
module dpc_pad_model (
  input wire logic ref_clk, // Paces the floating pattern
  input wire dpc_pkg::dpc_pad_type pad, // Pad controls from the block
  input wire logic [7:0] ext_en, // Outside driver active
  input wire logic [7:0] ext_val, // Outside driver level
  output logic [7:0] pin // Resolved pad level
);
  logic [7:0] float_reg = 8'h55;
  // Undriven pin without pull-up shows a changing pattern
  always @(posedge ref_clk) begin
    float_reg <= ~float_reg;
  end
  // Block drive first, then outside drive, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.out_en[i])
        pin[i] = pad.out_val[i];
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else if (pad.pullup_en[i])
        pin[i] = 1'b1;
      else
        pin[i] = float_reg[i];
    end
  end
endmodule // dpc_pad_model

// File: test/test_dual_port_pin_config_io.sv
`timescale 1ns/1ps
module test_dual_port_pin_config_io;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_irq_req, wake_req;
  logic [7:0] pin_in_a, pin_in_b, pin_sync_a, pin_sync_b;
  logic [7:0] ext_en_a = 8'h00;
  logic [7:0] ext_val_a = 8'h00;
  logic [7:0] ext_en_b = 8'h00;
  logic [7:0] ext_val_b = 8'h00;
  dpc_pkg::dpc_pad_type pad_a, pad_b;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] idx [6] = '{dpc_pkg::IDX_DATA_A, dpc_pkg::IDX_DATA_B, dpc_pkg::IDX_DIR_A,
    dpc_pkg::IDX_DIR_B, dpc_pkg::IDX_OPT_A, dpc_pkg::IDX_OPT_B};
  logic [7:0] val [6] = '{8'h3c, 8'hc3, 8'hff, 8'hff, 8'h5b, 8'ha5};
  logic [7:0] md [3] = '{8'haa, 8'haa, 8'h56};
  logic [7:0] mo [3] = '{8'hcc, 8'h33, 8'h33};

  dpc_gpio dpc_gpio_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in_a, .pin_in_b, .pad_a, .pad_b, .pin_sync_a,
    .pin_sync_b, .ext_irq_req, .wake_req);
  dpc_pad_model dpc_pad_model_inst_a (.ref_clk, .pad(pad_a), .ext_en(ext_en_a),
    .ext_val(ext_val_a), .pin(pin_in_a));
  dpc_pad_model dpc_pad_model_inst_b (.ref_clk, .pad(pad_b), .ext_en(ext_en_b),
    .ext_val(ext_val_b), .pin(pin_in_b));

  always #20 ref_clk = ~ref_clk;

  function automatic logic [11:0] ba(input logic [7:0] i);
    ba = {2'b00, i, 2'b00};
  endfunction

  function automatic dpc_pkg::dpc_pad_type exp_pad(input logic [7:0] d, r, o);
    exp_pad.out_en = r & (o | ~d);
    exp_pad.out_val = r & o & d;
    exp_pad.pullup_en = ~r & ~d;
    exp_pad.analog_sel = ~r & o & d;
    exp_pad.irq_en = ~r & o & ~d;
  endfunction

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, exp);
  endtask

  task automatic t_reset;
    repeat (2) @(posedge ref_clk);
    chk("pad_a", pad_a, exp_pad(8'h00, 8'h00, 8'h00));
    chk("pad_b", pad_b, exp_pad(8'h00, 8'h00, 8'h00));
    // Data reads show the pulled-up input pins, the rest read zero
    for (int i = 0; i < 6; i++) rdchk("reset reg", ba(idx[i]), (i < 2) ? 32'hff : 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    for (int i = 0; i < 6; i++) wr(ba(idx[(i + 2) % 6]), val[(i + 2) % 6]);
    wr(12'h008, 8'hff);
    chk("unmapped write err", er, 1'b1);
    rdchk("unmapped read", 12'h008, 32'h0);
    chk("unmapped read err", er, 1'b1);
    for (int i = 0; i < 6; i++) rdchk("reg rw", ba(idx[i]), val[i]);
    for (int i = 0; i < 6; i++) wr(ba(idx[i]), 8'h00);
    $display("test regs done");
  endtask

  task automatic t_modes;
    wr(ba(dpc_pkg::IDX_DIR_A), 8'hf0);
    for (int s = 0; s < 3; s++) begin
      // Order keeps one analog pin and no irq-analog hop
      wr(ba(dpc_pkg::IDX_DATA_A), md[s]);
      wr(ba(dpc_pkg::IDX_OPT_A), mo[s]);
      repeat (2) @(posedge ref_clk);
      chk("pad_a mode", pad_a, exp_pad(md[s], 8'hf0, mo[s]));
      chk("pad_a bits", pad_a.out_val[7:4], md[s][7:4] & mo[s][7:4]);
    end
    chk("irq off", ext_irq_req, 1'b0);
    $display("test modes done");
  endtask

  task automatic t_read;
    ext_en_a <= 8'h0f;
    ext_val_a <= 8'h09;
    repeat (4) @(posedge ref_clk);
    rdchk("mixed read", ba(dpc_pkg::IDX_DATA_A), 32'h59);
    chk("pin_sync_a", pin_sync_a[3:0], 4'h9);
    // Whole-word writes from a copy, no read-back merge
    wr(ba(dpc_pkg::IDX_OPT_A), 8'h00);
    wr(ba(dpc_pkg::IDX_DATA_A), 8'h00);
    wr(ba(dpc_pkg::IDX_DIR_A), 8'h00);
    ext_en_a <= 8'h00;
    $display("test read done");
  endtask

  task automatic t_irq;
    wr(ba(dpc_pkg::IDX_OPT_B), 8'h01);
    ext_en_b <= 8'h01;
    ext_val_b <= 8'h00;
    repeat (5) @(posedge ref_clk);
    chk("pad_b irq", pad_b, exp_pad(8'h00, 8'h00, 8'h01));
    chk("irq masked", ext_irq_req, 1'b0);
    wr(ba(dpc_pkg::IDX_IRQ_CTRL), 8'h01);
    repeat (4) @(posedge ref_clk);
    chk("irq on", ext_irq_req, 1'b1);
    chk("wake on", wake_req, 1'b1);
    rdchk("irq status", ba(dpc_pkg::IDX_IRQ_STAT), 32'h100);
    ext_val_b <= 8'h01;
    repeat (5) @(posedge ref_clk);
    chk("irq gone", ext_irq_req, 1'b0);
    chk("wake gone", wake_req, 1'b0);
    chk("pin_sync_b", pin_sync_b, 8'hff);
    wr(ba(dpc_pkg::IDX_IRQ_CTRL), 8'h00);
    ext_en_b <= 8'h00;
    wr(ba(dpc_pkg::IDX_OPT_B), 8'h00);
    // Float then analog, never straight from irq mode
    wr(ba(dpc_pkg::IDX_DATA_B), 8'h08);
    wr(ba(dpc_pkg::IDX_OPT_B), 8'h08);
    repeat (2) @(posedge ref_clk);
    chk("pad_b analog", pad_b, exp_pad(8'h08, 8'h00, 8'h08));
    wr(ba(dpc_pkg::IDX_OPT_B), 8'h00);
    wr(ba(dpc_pkg::IDX_DATA_B), 8'h00);
    $display("test irq done");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_read();
    t_irq();
    wrap_up();
  end
endmodule // test_dual_port_pin_config_io
